// *** sgt_pkg.sv ***
`default_nettype none
package sgt_pkg;
	// Register addresses on the special function register port
	localparam logic [7:0] SGT_ADDR_SVC = 8'ha6;
	localparam logic [7:0] SGT_ADDR_CTRL = 8'ha7;
	localparam logic [7:0] SGT_ADDR_STAT = 8'ha8;
	localparam logic [7:0] SGT_ADDR_CLR = 8'ha9;
	localparam logic [7:0] SGT_ADDR_EN = 8'haa;

	// Control register field positions
	localparam int SGT_CTRL_PS_LSB = 5;
	localparam int SGT_CTRL_IDLE_BIT = 4;
	localparam int SGT_CTRL_SOFT_BIT = 2;
	localparam int SGT_CTRL_OVF_BIT = 1;
	localparam int SGT_CTRL_RUN_BIT = 0;

	// Reset values
	localparam logic [2:0] SGT_PS_RESET = 3'h0;
	localparam logic SGT_FLAG_RESET = 1'b0;
	localparam logic [2:0] SGT_EV_RESET = 3'h0;

	// Service byte codes
	localparam logic [7:0] SGT_FEED_FIRST = 8'h1e;
	localparam logic [7:0] SGT_FEED_SECOND = 8'he1;
	localparam logic [7:0] SGT_SOFT_FIRST = 8'h5a;
	localparam logic [7:0] SGT_SOFT_SECOND = 8'ha5;

	// Counter chain geometry: timeout is 2^(PS+14) ticks
	localparam int SGT_PRE_WIDTH = 7;
	localparam int SGT_TIMER_WIDTH = 14;
	localparam int SGT_DIV_WIDTH = 4;
	localparam int SGT_PS_MAX = 7;

	// Event bits of the status, clear and enable registers
	localparam int SGT_EV_TIMEOUT = 0;
	localparam int SGT_EV_BADSEQ = 1;
	localparam int SGT_EV_SOFT = 2;
	localparam int SGT_EV_WIDTH = 3;

	typedef enum logic [1:0] {
		SGT_SEQ_IDLE,
		SGT_SEQ_FEED,
		SGT_SEQ_SOFT
	} sgt_seq_t;
endpackage : sgt_pkg
`default_nettype wire

// *** sgt_count.sv ***
`timescale 1ns/1ps
`default_nettype none
module sgt_count #(
	parameter int W = 7
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clr,
	input wire logic inc,
	input wire logic [W-1:0] limit,
	output logic [W-1:0] cnt_q,
	output logic wrap
);
	generate
		if (W < 1) begin : g_bad_width
			$error("sgt_count width must be at least one");
		end
	endgenerate

	// Compare with >= so a lowered limit cannot let the count run past it
	assign wrap = inc && (cnt_q >= limit);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= '0;
		end else if (clr || wrap) begin
			cnt_q <= '0;
		end else if (inc) begin
			cnt_q <= cnt_q + 1'b1;
		end
	end
endmodule : sgt_count
`default_nettype wire

// *** sgt_guard_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Unserviced timeout forces a system reset
// - Counter advances once per CPU clock
// - Period select gives 2^(PS+14) cycles
// - Clock divider multiplies period by divider+1
// - Disabled after reset, halted in power-down
// - Timeout emits internal reset pulse to CPU
// - 14-bit timer behind 7-bit prescaler
// - Bytes 1E then E1 start the timer
// - Running flag reads 1 while running
// - No other write between service bytes
// - Wrong sequence resets immediately
// - Wrong sequence sets soft and overflow flags
module sgt_guard_timer #(
	parameter int PRE_W = sgt_pkg::SGT_PRE_WIDTH,
	parameter int TMR_W = sgt_pkg::SGT_TIMER_WIDTH,
	parameter int DIV_W = sgt_pkg::SGT_DIV_WIDTH
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata_q,
	input wire logic [DIV_W-1:0] system_clock_divider,
	input wire logic power_down,
	input wire logic cpu_idle,
	output logic sys_reset_pulse_q,
	output logic irq
);
	localparam int FULL_W = PRE_W + TMR_W;
	localparam int EV_W = sgt_pkg::SGT_EV_WIDTH;

	// Tap selection assumes the chain spans exactly the largest period
	generate
		if (FULL_W != TMR_W + PRE_W || TMR_W != sgt_pkg::SGT_TIMER_WIDTH
				|| PRE_W != sgt_pkg::SGT_PS_MAX) begin : g_bad_chain
			$error("guard timer chain must be a 14-bit timer behind a 7-bit prescaler");
		end
		if (DIV_W < 1 || DIV_W > 8) begin : g_bad_div
			$error("divider width must be 1 to 8");
		end
	endgenerate

	// Register state
	sgt_pkg::sgt_seq_t seq_q;
	sgt_pkg::sgt_seq_t seq_d;
	logic run_q;
	logic run_d;
	logic [2:0] ps_q;
	logic idle_freeze_q;
	logic soft_flag_q;
	logic soft_flag_d;
	logic ovf_flag_q;
	logic ovf_flag_d;
	logic [EV_W-1:0] stat_q;
	logic [EV_W-1:0] stat_d;
	logic [EV_W-1:0] en_q;
	logic feed_ok;
	logic soft_ok;
	logic bad_seq;

	// Address decode
	wire svc_wr = reg_wr && (reg_addr == sgt_pkg::SGT_ADDR_SVC);
	wire other_wr = reg_wr && (reg_addr != sgt_pkg::SGT_ADDR_SVC);
	wire ctrl_wr = reg_wr && (reg_addr == sgt_pkg::SGT_ADDR_CTRL);
	wire clr_wr = reg_wr && (reg_addr == sgt_pkg::SGT_ADDR_CLR);
	wire en_wr = reg_wr && (reg_addr == sgt_pkg::SGT_ADDR_EN);
	wire ctrl_rd = reg_addr == sgt_pkg::SGT_ADDR_CTRL;
	wire stat_rd = reg_addr == sgt_pkg::SGT_ADDR_STAT;
	wire en_rd = reg_addr == sgt_pkg::SGT_ADDR_EN;

	// Service sequence checker; reads never disturb a half-done pair
	always_comb begin
		seq_d = seq_q;
		feed_ok = 1'b0;
		soft_ok = 1'b0;
		bad_seq = 1'b0;
		unique case (seq_q)
			sgt_pkg::SGT_SEQ_IDLE: begin
				if (svc_wr) begin
					if (reg_wdata == sgt_pkg::SGT_FEED_FIRST) begin
						seq_d = sgt_pkg::SGT_SEQ_FEED;
					end else if (reg_wdata == sgt_pkg::SGT_SOFT_FIRST) begin
						seq_d = sgt_pkg::SGT_SEQ_SOFT;
					end else begin
						bad_seq = 1'b1;
					end
				end
			end
			sgt_pkg::SGT_SEQ_FEED: begin
				if (svc_wr) begin
					seq_d = sgt_pkg::SGT_SEQ_IDLE;
					feed_ok = reg_wdata == sgt_pkg::SGT_FEED_SECOND;
					bad_seq = reg_wdata != sgt_pkg::SGT_FEED_SECOND;
				end else if (other_wr) begin
					seq_d = sgt_pkg::SGT_SEQ_IDLE;
					bad_seq = 1'b1;
				end
			end
			sgt_pkg::SGT_SEQ_SOFT: begin
				if (svc_wr) begin
					seq_d = sgt_pkg::SGT_SEQ_IDLE;
					soft_ok = reg_wdata == sgt_pkg::SGT_SOFT_SECOND;
					bad_seq = reg_wdata != sgt_pkg::SGT_SOFT_SECOND;
				end else if (other_wr) begin
					seq_d = sgt_pkg::SGT_SEQ_IDLE;
					bad_seq = 1'b1;
				end
			end
			default: begin
				seq_d = sgt_pkg::SGT_SEQ_IDLE;
			end
		endcase
	end

	// Counter chain: divider, prescaler, timer
	logic [DIV_W-1:0] div_cnt_q;
	logic [PRE_W-1:0] pre_cnt_q;
	logic [TMR_W-1:0] tmr_cnt_q;
	logic tick;
	logic pre_wrap;
	logic timeout_fire;

	wire cnt_en = run_q && !power_down && !(idle_freeze_q && cpu_idle);
	wire [FULL_W-1:0] full_w = {tmr_cnt_q, pre_cnt_q};
	// Period tap: PS=7 uses the whole chain, PS=0 only the low 14 bits
	wire [2:0] tap_shift = 3'h7 - ps_q;
	wire [FULL_W-1:0] mask_w = {FULL_W{1'b1}} >> tap_shift;
	wire expire = tick && (full_w == mask_w);
	// A feed landing on the final tick still counts as serviced
	assign timeout_fire = expire && !feed_ok;
	wire fire_d = timeout_fire || bad_seq || soft_ok;
	wire chain_clr = !run_q || feed_ok || fire_d;

	sgt_count #(
		.W(DIV_W)
	) u_div (
		.clk(clk),
		.rst_n(rst_n),
		.clr(chain_clr),
		.inc(cnt_en),
		.limit(system_clock_divider),
		.cnt_q(div_cnt_q),
		.wrap(tick)
	);

	sgt_count #(
		.W(PRE_W)
	) u_pre (
		.clk(clk),
		.rst_n(rst_n),
		.clr(chain_clr),
		.inc(tick),
		.limit({PRE_W{1'b1}}),
		.cnt_q(pre_cnt_q),
		.wrap(pre_wrap)
	);

	sgt_count #(
		.W(TMR_W)
	) u_tmr (
		.clk(clk),
		.rst_n(rst_n),
		.clr(chain_clr),
		.inc(pre_wrap),
		.limit({TMR_W{1'b1}}),
		.cnt_q(tmr_cnt_q),
		.wrap()
	);

	// Running state: any reset pulse disables the timer again
	assign run_d = fire_d ? 1'b0 : (feed_ok ? 1'b1 : run_q);

	// Cause flags: hardware set wins over a software clear
	assign soft_flag_d = (bad_seq || soft_ok) ? 1'b1 :
		((ctrl_wr && !reg_wdata[sgt_pkg::SGT_CTRL_SOFT_BIT]) ? 1'b0 : soft_flag_q);
	assign ovf_flag_d = (bad_seq || timeout_fire) ? 1'b1 :
		((ctrl_wr && !reg_wdata[sgt_pkg::SGT_CTRL_OVF_BIT]) ? 1'b0 : ovf_flag_q);

	// Sticky events; a new event beats a clear in the same cycle
	wire [EV_W-1:0] ev_w = {soft_ok, bad_seq, timeout_fire};
	wire [EV_W-1:0] clr_mask = clr_wr ? reg_wdata[EV_W-1:0] : '0;
	assign stat_d = ev_w | (stat_q & ~clr_mask);
	assign irq = |(stat_q & en_q);

	// Read mux; reserved bit 3 and write-only registers read zero
	wire [7:0] ctrl_view = {ps_q, idle_freeze_q, 1'b0, soft_flag_q, ovf_flag_q, run_q};
	wire [7:0] stat_view = {{(8 - EV_W){1'b0}}, stat_q};
	wire [7:0] en_view = {{(8 - EV_W){1'b0}}, en_q};
	wire [7:0] rd_mux = ctrl_rd ? ctrl_view : (stat_rd ? stat_view : (en_rd ? en_view : 8'h00));

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			seq_q <= sgt_pkg::SGT_SEQ_IDLE;
			run_q <= 1'b0;
			sys_reset_pulse_q <= 1'b0;
		end else begin
			seq_q <= seq_d;
			run_q <= run_d;
			sys_reset_pulse_q <= fire_d;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ps_q <= sgt_pkg::SGT_PS_RESET;
			idle_freeze_q <= sgt_pkg::SGT_FLAG_RESET;
			soft_flag_q <= sgt_pkg::SGT_FLAG_RESET;
			ovf_flag_q <= sgt_pkg::SGT_FLAG_RESET;
		end else begin
			if (ctrl_wr) begin
				ps_q <= reg_wdata[sgt_pkg::SGT_CTRL_PS_LSB +: 3];
				idle_freeze_q <= reg_wdata[sgt_pkg::SGT_CTRL_IDLE_BIT];
			end
			soft_flag_q <= soft_flag_d;
			ovf_flag_q <= ovf_flag_d;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stat_q <= sgt_pkg::SGT_EV_RESET;
			en_q <= sgt_pkg::SGT_EV_RESET;
			reg_rdata_q <= 8'h00;
		end else begin
			stat_q <= stat_d;
			if (en_wr) begin
				en_q <= reg_wdata[EV_W-1:0];
			end
			reg_rdata_q <= reg_rd ? rd_mux : 8'h00;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	sequence s_feed_pair;
		(svc_wr && reg_wdata == sgt_pkg::SGT_FEED_FIRST && seq_q == sgt_pkg::SGT_SEQ_IDLE)
			##1 (svc_wr && reg_wdata == sgt_pkg::SGT_FEED_SECOND);
	endsequence

	sequence s_bad_second;
		(svc_wr && reg_wdata == sgt_pkg::SGT_FEED_FIRST && seq_q == sgt_pkg::SGT_SEQ_IDLE)
			##1 (svc_wr && reg_wdata != sgt_pkg::SGT_FEED_SECOND);
	endsequence

	a_timeout_reset: assert property (timeout_fire |=> sys_reset_pulse_q && ovf_flag_q && !run_q)
		else $error("timeout did not raise the reset pulse");
	a_tick_rate: assert property (cnt_en && system_clock_divider == '0 |-> tick)
		else $error("undivided chain missed a cycle");
	a_short_period: assert property (tick && ps_q == 3'h0 && pre_cnt_q == {PRE_W{1'b1}}
			&& tmr_cnt_q[6:0] == 7'h7f && tmr_cnt_q[TMR_W-1:7] == '0
			&& !feed_ok |=> sys_reset_pulse_q)
		else $error("shortest period did not expire");
	a_divider_stretch: assert property (tick && system_clock_divider != '0 |=> !tick)
		else $error("divider did not stretch the tick");
	a_pulse_disables: assert property (sys_reset_pulse_q |-> !run_q)
		else $error("timer still running after reset pulse");
	a_power_down_hold: assert property (power_down && !fire_d && !feed_ok
			|=> $stable(full_w))
		else $error("counter moved in power-down");
	a_enable_pair: assert property (s_feed_pair |=> run_q && full_w == '0)
		else $error("feed pair did not start and clear the timer");
	a_running_visible: assert property (reg_rd && ctrl_rd
			|=> reg_rdata_q[sgt_pkg::SGT_CTRL_RUN_BIT] == $past(run_q))
		else $error("running flag read back wrong");
	a_write_between: assert property (seq_q != sgt_pkg::SGT_SEQ_IDLE && other_wr
			|=> sys_reset_pulse_q)
		else $error("foreign write inside pair not punished");
	a_bad_flags: assert property (s_bad_second
			|=> sys_reset_pulse_q && soft_flag_q && ovf_flag_q)
		else $error("wrong sequence did not reset with both flags");
	a_feed_restarts: assert property (feed_ok |=> full_w == '0 && div_cnt_q == '0)
		else $error("feed did not clear the chain");
endmodule : sgt_guard_timer
`default_nettype wire

// *** sgt_cpu_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module sgt_cpu_model (
	input wire logic clk,
	input wire logic [7:0] reg_rdata_q,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd
);
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		// Stale data must not look valid after release
		reg_wdata <= ~d;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata_q;
	endtask : rd
	// Pair written back to back, nothing else written between
	task automatic pair(input logic [7:0] d0, input logic [7:0] d1);
		@(posedge clk);
		reg_addr <= sgt_pkg::SGT_ADDR_SVC;
		reg_wdata <= d0;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wdata <= d1;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_wdata <= ~d1;
	endtask : pair
	task automatic feed();
		pair(sgt_pkg::SGT_FEED_FIRST, sgt_pkg::SGT_FEED_SECOND);
	endtask : feed
endmodule : sgt_cpu_model
`default_nettype wire

// *** sequenced_watchdog_timer_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module sequenced_watchdog_timer_tb_top;
	localparam logic [7:0] A_SVC = sgt_pkg::SGT_ADDR_SVC;
	localparam logic [7:0] A_CTRL = sgt_pkg::SGT_ADDR_CTRL;
	localparam logic [7:0] A_STAT = sgt_pkg::SGT_ADDR_STAT;
	localparam logic [7:0] A_CLR = sgt_pkg::SGT_ADDR_CLR;
	localparam logic [7:0] A_EN = sgt_pkg::SGT_ADDR_EN;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata_q;
	logic reg_wr;
	logic reg_rd;
	logic [sgt_pkg::SGT_DIV_WIDTH-1:0] system_clock_divider = '0;
	logic power_down = 1'b0;
	logic cpu_idle = 1'b0;
	logic sys_reset_pulse_q;
	logic irq;
	int n_mismatch = 0;
	int samples_checked = 0;
	logic [7:0] rdv;
	logic [31:0] n;
	always #12.5 clk = ~clk;
	sgt_guard_timer sgt_guard_timer_i (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
		.system_clock_divider(system_clock_divider), .power_down(power_down),
		.cpu_idle(cpu_idle), .sys_reset_pulse_q(sys_reset_pulse_q), .irq(irq));
	sgt_cpu_model sgt_cpu_model_i (.clk(clk), .reg_rdata_q(reg_rdata_q), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
	task automatic finish_test();
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : finish_test
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
		sgt_cpu_model_i.rd(a, rdv);
		check({24'h0, rdv}, {24'h0, exp});
	endtask : rd_check
	// Edges from the launching edge until the reset pulse shows
	task automatic wait_pulse(input int max);
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (sys_reset_pulse_q !== 1'b1 && n < max);
		if (sys_reset_pulse_q !== 1'b1) begin
			n_mismatch++;
			finish_test();
		end
	endtask : wait_pulse
	task automatic t_reset();
		rd_check(A_CTRL, 8'h00);
		rd_check(A_STAT, 8'h00);
		@(posedge clk);
		#1;
		check(reg_rdata_q, 8'h00);
		check(irq, 1'b0);
	endtask : t_reset
	task automatic t_feed();
		sgt_cpu_model_i.wr(A_SVC, sgt_pkg::SGT_FEED_FIRST);
		rd_check(A_CTRL, 8'h00);
		sgt_cpu_model_i.wr(A_SVC, sgt_pkg::SGT_FEED_SECOND);
		rd_check(A_CTRL, 8'h01);
		repeat (10000) @(posedge clk);
		sgt_cpu_model_i.feed();
		wait_pulse(20000);
		check(n, 32'd16384);
		@(posedge clk);
		#1;
		check(sys_reset_pulse_q, 1'b0);
		rd_check(A_CTRL, 8'h02);
		rd_check(A_STAT, 8'h01);
	endtask : t_feed
	// Divider doubles the period; power-down and idle freeze add their length
	task automatic t_divider();
		sgt_cpu_model_i.wr(A_CLR, 8'h07);
		sgt_cpu_model_i.wr(A_CTRL, 8'h10);
		system_clock_divider <= 4'h1;
		sgt_cpu_model_i.feed();
		repeat (100) @(posedge clk);
		power_down <= 1'b1;
		repeat (1000) @(posedge clk);
		power_down <= 1'b0;
		cpu_idle <= 1'b1;
		repeat (500) @(posedge clk);
		cpu_idle <= 1'b0;
		wait_pulse(40000);
		check(n + 32'd1600, 32'd34268);
		@(posedge clk);
		system_clock_divider <= 4'h0;
	endtask : t_divider
	task automatic t_bad_seq();
		sgt_cpu_model_i.wr(A_CLR, 8'h07);
		sgt_cpu_model_i.wr(A_CTRL, 8'h00);
		sgt_cpu_model_i.wr(A_EN, 8'h02);
		sgt_cpu_model_i.wr(A_SVC, 8'h00);
		#1;
		check(sys_reset_pulse_q, 1'b1);
		rd_check(A_CTRL, 8'h06);
		rd_check(A_STAT, 8'h02);
		check(irq, 1'b1);
		sgt_cpu_model_i.wr(A_CLR, 8'h02);
		#1;
		check(irq, 1'b0);
		sgt_cpu_model_i.wr(A_EN, 8'h00);
		sgt_cpu_model_i.wr(A_SVC, sgt_pkg::SGT_FEED_FIRST);
		// Any register write splits the pair, even a harmless one
		sgt_cpu_model_i.wr(A_EN, 8'h00);
		#1;
		check(sys_reset_pulse_q, 1'b1);
		rd_check(A_STAT, 8'h02);
		check(irq, 1'b0);
		sgt_cpu_model_i.pair(sgt_pkg::SGT_FEED_FIRST, 8'h00);
		#1;
		check(sys_reset_pulse_q, 1'b1);
		sgt_cpu_model_i.wr(A_CLR, 8'h07);
		sgt_cpu_model_i.wr(A_CTRL, 8'h00);
		// Intended soft reset sets only the soft flag
		sgt_cpu_model_i.pair(sgt_pkg::SGT_SOFT_FIRST, sgt_pkg::SGT_SOFT_SECOND);
		#1;
		check(sys_reset_pulse_q, 1'b1);
		rd_check(A_CTRL, 8'h04);
		rd_check(A_STAT, 8'h04);
	endtask : t_bad_seq
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_feed();
		t_divider();
		t_bad_seq();
		// Reset while running must stop the timer
		sgt_cpu_model_i.feed();
		@(posedge clk);
		rst_n <= 1'b0;
		@(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		finish_test();
	end
endmodule : sequenced_watchdog_timer_tb_top
`default_nettype wire
